//--- rtl/gpio_output_mux.sv
/*
 * top of the general-pin output mux and overflow flags block, with its
 * byte-wide two-wire control port slave (page-zero registers only).
 * assumes scl/sda arrive from pins, all other inputs on ref_clk, and the
 * direction and pin-zero/one selectors are held by registers elsewhere.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_output_mux (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic [6:0]         dev_addr,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	input  wire gpio_mux_pkg::sel_t pin0_sel,
	input  wire gpio_mux_pkg::sel_t pin1_sel,
	input  wire logic [2:0]         pin_direction_out,
	input  wire logic [2:0]         dsp_pin_out,
	input  wire logic               automute_a,
	input  wire logic               automute_b,
	input  wire logic               clock_error,
	input  wire logic               clock_changing,
	input  wire logic               clock_missing,
	input  wire logic               serial_audio_out,
	input  wire logic               analog_mute_a_n,
	input  wire logic               analog_mute_b_n,
	input  wire logic               pll_lock,
	input  wire logic               charge_pump_clk,
	input  wire logic               speaker_mute_uv_high,
	input  wire logic               speaker_mute_uv_low,
	input  wire logic               pll_div4,
	input  wire logic               clock_flex_enable,
	input  wire logic               ovf_b1,
	input  wire logic               ovf_a1,
	input  wire logic               ovf_b2,
	input  wire logic               ovf_a2,
	input  wire logic               ovf_shift,
	output logic [2:0]              general_pin_out,
	output logic [2:0]              general_pin_oe
);
	import gpio_mux_pkg::*;

	// ----------------------------------------
	// control-port state
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_ADDR  = 4'b0001,
		ST_ACK_A = 4'b0010,
		ST_PTR   = 4'b0011,
		ST_ACK_P = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_ACK_W = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_ACK_R = 4'b1000
	} port_state_e;

	port_state_e state;
	logic [3:0]  bit_cnt;
	logic [7:0]  shreg;
	logic [7:0]  tx_byte;
	logic [7:0]  ptr;
	logic        read_mode;
	logic        wr_pulse;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        rd_pulse;
	logic [7:0]  rd_addr;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	sel_t        pin2_sel;
	logic [2:0]  level_bits;
	logic [1:0]  invert_bits;
	logic [4:0]  ovf_status;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic scl_m;
	logic scl_s;
	logic scl_d;
	logic sda_m;
	logic sda_s;
	logic sda_d;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end

	wire scl_rise   = scl_s & ~scl_d;
	wire scl_fall   = ~scl_s & scl_d;
	wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
	wire byte_done  = (bit_cnt == 4'h8);
	wire addr_match = (shreg[7:1] == dev_addr);
	wire receiving  = (state == ST_ADDR) | (state == ST_PTR) | (state == ST_WDATA);
	wire [7:0] ptr_inc = ptr + 8'h01;

	// ----------------------------------------
	// read data selection
	// ----------------------------------------
	wire sel_hit   = (ptr == OFF_PIN2_SEL);
	wire level_hit = (ptr == OFF_LEVEL);
	wire inv_hit   = (ptr == OFF_INVERT);
	wire ovf_hit   = (ptr == OFF_OVF_STATUS);

	wire [7:0] level_view = {2'h0, level_bits[2], 1'b0, level_bits[1], level_bits[0], 2'h0};
	wire [7:0] inv_view   = {2'h0, invert_bits[1], 1'b0, invert_bits[0], 3'h0};

	// unmapped and reserved bits read back as zero
	wire [7:0] rd_value = sel_hit   ? {3'h0, pin2_sel} :
	                      level_hit ? level_view :
	                      inv_hit   ? inv_view :
	                      ovf_hit   ? {3'h0, ovf_status} :
	                      8'h00;

	// ----------------------------------------
	// control-port sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state     <= ST_IDLE;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			tx_byte   <= 8'h00;
			ptr       <= 8'h00;
			read_mode <= 1'b0;
			sda_oe    <= 1'b0;
			wr_pulse  <= 1'b0;
			wr_addr   <= 8'h00;
			wr_data   <= 8'h00;
			rd_pulse  <= 1'b0;
			rd_addr   <= 8'h00;
		end else begin
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			if (start_cond) begin
				state   <= ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end else if (stop_cond) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (receiving) begin
					shreg   <= {shreg[6:0], sda_s};
					bit_cnt <= bit_cnt + 4'h1;
				end else if (state == ST_RDATA) begin
					bit_cnt <= bit_cnt + 4'h1;
				end else if (state == ST_ACK_R) begin
					// master nack ends the read burst
					read_mode <= ~sda_s;
				end
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						if (byte_done) begin
							if (addr_match) begin
								state     <= ST_ACK_A;
								read_mode <= shreg[0];
								sda_oe    <= 1'b1;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					ST_ACK_A: begin
						bit_cnt <= 4'h0;
						if (read_mode) begin
							state    <= ST_RDATA;
							tx_byte  <= rd_value;
							rd_pulse <= 1'b1;
							rd_addr  <= ptr;
							ptr      <= ptr_inc;
							sda_oe   <= ~rd_value[7];
						end else begin
							state  <= ST_PTR;
							sda_oe <= 1'b0;
						end
					end
					ST_PTR: begin
						if (byte_done) begin
							state  <= ST_ACK_P;
							ptr    <= shreg;
							sda_oe <= 1'b1;
						end
					end
					ST_ACK_P, ST_ACK_W: begin
						state   <= ST_WDATA;
						bit_cnt <= 4'h0;
						sda_oe  <= 1'b0;
					end
					ST_WDATA: begin
						if (byte_done) begin
							state    <= ST_ACK_W;
							wr_pulse <= 1'b1;
							wr_addr  <= ptr;
							wr_data  <= shreg;
							ptr      <= ptr_inc;
							sda_oe   <= 1'b1;
						end
					end
					ST_RDATA: begin
						if (byte_done) begin
							state  <= ST_ACK_R;
							sda_oe <= 1'b0;
						end else begin
							sda_oe <= ~tx_byte[3'(4'h7 - bit_cnt)];
						end
					end
					ST_ACK_R: begin
						bit_cnt <= 4'h0;
						if (read_mode) begin
							state    <= ST_RDATA;
							tx_byte  <= rd_value;
							rd_pulse <= 1'b1;
							rd_addr  <= ptr;
							ptr      <= ptr_inc;
							sda_oe   <= ~rd_value[7];
						end else begin
							state <= ST_IDLE;
						end
					end
					default: begin
						state  <= ST_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	wire wr_sel   = wr_pulse & (wr_addr == OFF_PIN2_SEL);
	wire wr_level = wr_pulse & (wr_addr == OFF_LEVEL);
	wire wr_inv   = wr_pulse & (wr_addr == OFF_INVERT);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin2_sel    <= RST_PIN2_SEL;
			level_bits  <= RST_LEVEL;
			invert_bits <= RST_INVERT;
		end else begin
			if (wr_sel) begin
				pin2_sel <= wr_data[4:0];
			end
			if (wr_level) begin
				level_bits <= {wr_data[BIT_LEVEL_PIN2], wr_data[BIT_LEVEL_PIN0],
				               wr_data[BIT_LEVEL_PIN1]};
			end
			if (wr_inv) begin
				invert_bits <= {wr_data[BIT_INV_PIN2], wr_data[BIT_INV_PIN0]};
			end
		end
	end

	// ----------------------------------------
	// sticky overflow flags
	// ----------------------------------------
	wire       ovf_read = rd_pulse & (rd_addr == OFF_OVF_STATUS);
	wire [4:0] ovf_event;

	assign ovf_event[BIT_OVF_B1]    = ovf_b1;
	assign ovf_event[BIT_OVF_A1]    = ovf_a1;
	assign ovf_event[BIT_OVF_B2]    = ovf_b2;
	assign ovf_event[BIT_OVF_A2]    = ovf_a2;
	assign ovf_event[BIT_OVF_SHIFT] = ovf_shift;

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_ovf
			// a new event beats the read clear; one on the edge that captures the read byte is cleared unread
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					ovf_status[gi] <= RST_OVF_STATUS[gi];
				end else if (ovf_event[gi]) begin
					ovf_status[gi] <= 1'b1;
				end else if (ovf_read) begin
					ovf_status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// pin outputs
	// ----------------------------------------
	wire       clock_invalid = clock_error | clock_changing | clock_missing;
	wire [2:0] pin_value;
	wire [2:0] pin_invert = {invert_bits[1], 1'b0, invert_bits[0]};
	sel_t      pin_sel [3];

	assign pin_sel[0] = pin0_sel;
	assign pin_sel[1] = pin1_sel;
	assign pin_sel[2] = pin2_sel;

	// level_bits holds {pin two, pin zero, pin one}
	wire [2:0] pin_level = {level_bits[2], level_bits[0], level_bits[1]};

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
			gpio_source_mux u_mux (
				.sel               (pin_sel[gi]),
				.dsp_pin           (dsp_pin_out[gi]),
				.reg_level         (pin_level[gi]),
				.invert            (pin_invert[gi]),
				.automute_a        (automute_a),
				.automute_b        (automute_b),
				.clock_invalid     (clock_invalid),
				.serial_audio_out  (serial_audio_out),
				.analog_mute_a_n   (analog_mute_a_n),
				.analog_mute_b_n   (analog_mute_b_n),
				.pll_lock          (pll_lock),
				.charge_pump_clk   (charge_pump_clk),
				.uv_high           (speaker_mute_uv_high),
				.uv_low            (speaker_mute_uv_low),
				.pll_div4          (pll_div4),
				.clock_flex_enable (clock_flex_enable),
				.pin_value         (pin_value[gi])
			);
		end
	endgenerate

	// registered outputs add one cycle of latency to every source
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			general_pin_out <= 3'h0;
			general_pin_oe  <= 3'h0;
		end else begin
			general_pin_out <= pin_value;
			general_pin_oe  <= pin_direction_out;
		end
	end

endmodule

`default_nettype wire

//--- rtl/gpio_mux_pkg.sv
/*
 * constants for the general-pin output mux and overflow flags block:
 * register offsets, field positions, reset values, selector codes.
 * assumes a single clock domain and a byte-wide control-port register map.
 */

package gpio_mux_pkg;

	typedef logic [4:0] sel_t;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_PIN2_SEL    = 8'h55;
	localparam logic [7:0] OFF_LEVEL       = 8'h56;
	localparam logic [7:0] OFF_INVERT      = 8'h57;
	localparam logic [7:0] OFF_OVF_STATUS  = 8'h5a;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [4:0] RST_PIN2_SEL    = 5'h00;
	localparam logic [2:0] RST_LEVEL       = 3'h0;
	localparam logic [1:0] RST_INVERT      = 2'h0;
	localparam logic [4:0] RST_OVF_STATUS  = 5'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_LEVEL_PIN2  = 5;
	localparam int BIT_LEVEL_PIN0  = 3;
	localparam int BIT_LEVEL_PIN1  = 2;
	localparam int BIT_INV_PIN2    = 5;
	localparam int BIT_INV_PIN0    = 3;
	localparam int BIT_OVF_B1      = 4;
	localparam int BIT_OVF_A1      = 3;
	localparam int BIT_OVF_B2      = 2;
	localparam int BIT_OVF_A2      = 1;
	localparam int BIT_OVF_SHIFT   = 0;

	// ----------------------------------------
	// selector codes
	// ----------------------------------------
	localparam sel_t SEL_OFF        = 5'h00;
	localparam sel_t SEL_DSP        = 5'h01;
	localparam sel_t SEL_REG        = 5'h02;
	localparam sel_t SEL_MUTE_BOTH  = 5'h03;
	localparam sel_t SEL_MUTE_B     = 5'h04;
	localparam sel_t SEL_MUTE_A     = 5'h05;
	localparam sel_t SEL_CLK_BAD    = 5'h06;
	localparam sel_t SEL_SER_OUT    = 5'h07;
	localparam sel_t SEL_AMUTE_B_N  = 5'h08;
	localparam sel_t SEL_AMUTE_A_N  = 5'h09;
	localparam sel_t SEL_PLL_LOCK   = 5'h0a;
	localparam sel_t SEL_CP_CLK     = 5'h0b;
	localparam sel_t SEL_UV_HIGH    = 5'h0e;
	localparam sel_t SEL_UV_LOW     = 5'h0f;
	localparam sel_t SEL_PLL_DIV4   = 5'h10;

	// ----------------------------------------
	// control port
	// ----------------------------------------
	// arbitrary neutral default, straps set the real one
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

endpackage

//--- rtl/gpio_source_mux.sv
/*
 * one general pin's source selector and polarity stage, combinational.
 * assumes all sources are already in the ref_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_source_mux (
	input  wire gpio_mux_pkg::sel_t sel,
	input  wire logic               dsp_pin,
	input  wire logic               reg_level,
	input  wire logic               invert,
	input  wire logic               automute_a,
	input  wire logic               automute_b,
	input  wire logic               clock_invalid,
	input  wire logic               serial_audio_out,
	input  wire logic               analog_mute_a_n,
	input  wire logic               analog_mute_b_n,
	input  wire logic               pll_lock,
	input  wire logic               charge_pump_clk,
	input  wire logic               uv_high,
	input  wire logic               uv_low,
	input  wire logic               pll_div4,
	input  wire logic               clock_flex_enable,
	output logic                    pin_value
);
	import gpio_mux_pkg::*;

	// ----------------------------------------
	// source table
	// ----------------------------------------
	logic [31:0] src_table;
	logic        selected;

	// unlisted entries stay zero, so reserved codes select low ahead of the invert stage
	always_comb begin
		src_table                = 32'h00000000;
		src_table[SEL_OFF]       = 1'b0;
		src_table[SEL_DSP]       = dsp_pin;
		src_table[SEL_REG]       = reg_level;
		src_table[SEL_MUTE_BOTH] = automute_a & automute_b;
		src_table[SEL_MUTE_B]    = automute_b;
		src_table[SEL_MUTE_A]    = automute_a;
		src_table[SEL_CLK_BAD]   = clock_invalid;
		src_table[SEL_SER_OUT]   = serial_audio_out;
		src_table[SEL_AMUTE_B_N] = analog_mute_b_n;
		src_table[SEL_AMUTE_A_N] = analog_mute_a_n;
		src_table[SEL_PLL_LOCK]  = pll_lock;
		src_table[SEL_CP_CLK]    = charge_pump_clk;
		src_table[SEL_UV_HIGH]   = uv_high;
		src_table[SEL_UV_LOW]    = uv_low;
		// pll/4 is only meaningful with the flex clock setting on
		src_table[SEL_PLL_DIV4]  = pll_div4 & clock_flex_enable;
	end

	assign selected  = src_table[sel];
	assign pin_value = selected ^ invert;

endmodule

`default_nettype wire

//--- verif/gpio_output_mux_chk.sv
/* checker for the general-pin mux top: pin one source codes, enable delay.
   assumes binding to gpio_output_mux, one clock, async active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module gpio_output_mux_chk (
	input wire logic               ref_clk,
	input wire logic               rst,
	input wire gpio_mux_pkg::sel_t pin1_sel,
	input wire logic [2:0]         pin_direction_out,
	input wire logic [2:0]         dsp_pin_out,
	input wire logic               automute_a,
	input wire logic               automute_b,
	input wire logic               clock_error,
	input wire logic               clock_changing,
	input wire logic               clock_missing,
	input wire logic               serial_audio_out,
	input wire logic               analog_mute_b_n,
	input wire logic               speaker_mute_uv_high,
	input wire logic               pll_div4,
	input wire logic               clock_flex_enable,
	input wire logic [2:0]         general_pin_out,
	input wire logic [2:0]         general_pin_oe
);
	import gpio_mux_pkg::*;
	logic up;
	// pin one has no invert stage, so for every code but SEL_REG its value follows from ports alone
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			up <= 1'b0;
		end else begin
			up <= 1'b1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_oe_delay: assert property (
		up |-> general_pin_oe == $past(pin_direction_out)) else $error("pin enable wrong");
	chk_off_low: assert property (
		up && $past(pin1_sel) == SEL_OFF |-> !general_pin_out[1]) else $error("off not low");
	chk_dsp_route: assert property (
		up && $past(pin1_sel) == SEL_DSP |-> general_pin_out[1] == $past(dsp_pin_out[1]))
		else $error("processor pin not routed");
	chk_mute_both: assert property (
		up && $past(pin1_sel) == SEL_MUTE_BOTH |-> general_pin_out[1] ==
		($past(automute_a) && $past(automute_b))) else $error("joint mute flag wrong");
	chk_clock_bad: assert property (
		up && $past(pin1_sel) == SEL_CLK_BAD |-> general_pin_out[1] == $past(clock_error
		|| clock_changing || clock_missing)) else $error("clock invalid flag wrong");
	chk_serial_out: assert property (
		up && $past(pin1_sel) == SEL_SER_OUT |-> general_pin_out[1] == $past(serial_audio_out))
		else $error("serial stream not routed");
	chk_amute_b: assert property (
		up && $past(pin1_sel) == SEL_AMUTE_B_N |-> general_pin_out[1] == $past(analog_mute_b_n))
		else $error("analog mute b wrong");
	chk_uv_high: assert property (
		up && $past(pin1_sel) == SEL_UV_HIGH
		|-> general_pin_out[1] == $past(speaker_mute_uv_high)) else $error("uv flag wrong");
	chk_pll_div: assert property (
		up && $past(pin1_sel) == SEL_PLL_DIV4 |-> general_pin_out[1] ==
		($past(pll_div4) && $past(clock_flex_enable))) else $error("pll quarter wrong");
	chk_reserved_low: assert property (
		up && ($past(pin1_sel) > 5'h10 || $past(pin1_sel) inside {5'h0c, 5'h0d})
		|-> !general_pin_out[1]) else $error("reserved code not low");
endmodule
bind gpio_output_mux gpio_output_mux_chk chk (.ref_clk, .rst, .pin1_sel, .pin_direction_out,
	.dsp_pin_out, .automute_a, .automute_b, .clock_error, .clock_changing, .clock_missing,
	.serial_audio_out, .analog_mute_b_n, .speaker_mute_uv_high, .pll_div4,
	.clock_flex_enable, .general_pin_out, .general_pin_oe);
`default_nettype wire

//--- verif/gpio_pin_sampler.sv
/* board-side model sampling the three general pins.
   assumes each pin has a pull-down, so a released pin reads low. */
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_sampler (
	input wire logic       ref_clk,
	input wire logic [2:0] pin_value,
	input wire logic [2:0] pin_oe,
	output logic [2:0]     pin_level
);
	wire logic [2:0] wire_level = pin_value & pin_oe;
	always_ff @(posedge ref_clk) begin
		pin_level <= wire_level;
	end
endmodule
`default_nettype wire

//--- verif/gpio_output_mux_and_overflow_flags_bench.sv
/* testbench: register access over the two-wire port, pin source sweep, overflow flags.
   assumes the design top gpio_output_mux and the pin sampler model. */
`timescale 1ns/1ps
`default_nettype none
module gpio_output_mux_and_overflow_flags_bench;
	import gpio_mux_pkg::*;
	logic ref_clk, rst, scl_in, sda_m, sda_out, sda_oe, ack;
	logic [6:0] dev_addr;
	sel_t pin0_sel, pin1_sel;
	logic [2:0] pin_direction_out, general_pin_out, general_pin_oe, pin_level, e;
	logic [16:0] src;
	logic [4:0] ovf;
	logic [7:0] rd;
	int bad_count, cmp_count;
	logic [16:0] pats [4] = '{17'h00000, 17'h1ffff, 17'h0a5c9, 17'h15a36};
	logic [7:0] invs [2] = '{8'h00, 8'h28};
	logic [7:0] lvls [2] = '{8'h24, 8'h08};
	// pull-up on sda: the device only ever pulls low
	wire logic sda_in = sda_oe ? 1'b0 : sda_m;
	gpio_output_mux dut (.ref_clk(ref_clk), .rst(rst), .dev_addr(dev_addr), .scl_in(scl_in),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .pin0_sel(pin0_sel),
		.pin1_sel(pin1_sel), .pin_direction_out(pin_direction_out), .dsp_pin_out(src[2:0]),
		.automute_a(src[3]), .automute_b(src[4]), .clock_error(src[5]),
		.clock_changing(src[6]), .clock_missing(src[7]), .serial_audio_out(src[8]),
		.analog_mute_a_n(src[9]), .analog_mute_b_n(src[10]), .pll_lock(src[11]),
		.charge_pump_clk(src[12]), .speaker_mute_uv_high(src[13]),
		.speaker_mute_uv_low(src[14]), .pll_div4(src[15]), .clock_flex_enable(src[16]),
		.ovf_b1(ovf[4]), .ovf_a1(ovf[3]), .ovf_b2(ovf[2]), .ovf_a2(ovf[1]),
		.ovf_shift(ovf[0]), .general_pin_out(general_pin_out), .general_pin_oe(general_pin_oe));
	gpio_pin_sampler board (.ref_clk(ref_clk), .pin_value(general_pin_out),
		.pin_oe(general_pin_oe), .pin_level(pin_level));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// seven cycles a phase keeps both scl phases and sda setup/hold in margin
	task automatic step(input logic s, input logic d);
		@(posedge ref_clk);
		scl_in <= s;
		sda_m <= d;
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q);
		for (int i = 8; i >= 0; i--) begin
			step(1'b0, (i == 0) ? last : d[i-1]);
			step(1'b1, (i == 0) ? last : d[i-1]);
			if (i == 0) ack = sda_in;
			else q[i-1] = sda_in;
			step(1'b0, (i == 0) ? last : d[i-1]);
		end
	endtask
	task automatic start(input logic [6:0] a, input logic dir);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		xbyte({a, dir}, 1'b1, rd);
	endtask
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	task automatic point(input logic [7:0] off);
		start(dev_addr, 1'b0);
		check({7'h0, ack}, 8'h00);
		xbyte(off, 1'b1, rd);
		check({7'h0, ack}, 8'h00);
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		point(off);
		xbyte(d, 1'b1, rd);
		check({7'h0, ack}, 8'h00);
		stop();
	endtask
	task automatic rdr(input logic [7:0] off, input logic [7:0] exp);
		point(off);
		start(dev_addr, 1'b1);
		check({7'h0, ack}, 8'h00);
		xbyte(8'hff, 1'b1, rd);
		stop();
		check(rd, exp);
		check({7'h0, sda_out}, 8'h00);
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge ref_clk);
		ovf <= v;
		@(posedge ref_clk);
		ovf <= 5'h00;
	endtask
	function automatic logic src_val(input logic [4:0] c, input int i, input logic l);
		case (c)
			SEL_DSP: return src[i];
			SEL_REG: return l;
			SEL_MUTE_BOTH: return src[3] & src[4];
			SEL_MUTE_B: return src[4];
			SEL_MUTE_A: return src[3];
			SEL_CLK_BAD: return |src[7:5];
			SEL_SER_OUT: return src[8];
			SEL_AMUTE_B_N: return src[10];
			SEL_AMUTE_A_N: return src[9];
			SEL_PLL_LOCK: return src[11];
			SEL_CP_CLK: return src[12];
			SEL_UV_HIGH: return src[13];
			SEL_UV_LOW: return src[14];
			SEL_PLL_DIV4: return src[15] & src[16];
			default: return 1'b0;
		endcase
	endfunction
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		bad_count++;
		finish_test();
	end
	initial begin
		rst = 1'b1;
		{scl_in, sda_m} = 2'b11;
		dev_addr = DEV_ADDR_DEFAULT;
		{pin0_sel, pin1_sel, pin_direction_out, src, ovf} = '0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rdr(OFF_PIN2_SEL, 8'h00);
		rdr(OFF_LEVEL, 8'h00);
		rdr(OFF_INVERT, 8'h00);
		rdr(OFF_OVF_STATUS, 8'h00);
		rdr(8'h60, 8'h00);
		start(dev_addr ^ 7'h01, 1'b0);
		check({7'h0, ack}, 8'h01);
		stop();
		wr(OFF_PIN2_SEL, 8'hff);
		rdr(OFF_PIN2_SEL, 8'h1f);
		wr(OFF_LEVEL, 8'hff);
		rdr(OFF_LEVEL, 8'h2c);
		wr(OFF_INVERT, 8'hff);
		rdr(OFF_INVERT, 8'h28);
		wr(OFF_OVF_STATUS, 8'hff);
		rdr(OFF_OVF_STATUS, 8'h00);
		$display("registers done");
		for (int k = 0; k < 2; k++) begin
			wr(OFF_INVERT, invs[k]);
			wr(OFF_LEVEL, lvls[k]);
			for (int c = 0; c < 32; c++) begin
				wr(OFF_PIN2_SEL, 8'(c));
				@(posedge ref_clk);
				pin0_sel <= 5'(c);
				pin1_sel <= 5'(c);
				for (int p = 0; p < 4; p++) begin
					@(posedge ref_clk);
					src <= pats[p];
					pin_direction_out <= pats[p][2:0];
					repeat (3) @(posedge ref_clk);
					e[2] = src_val(5'(c), 2, lvls[k][5]) ^ invs[k][5];
					e[1] = src_val(5'(c), 1, lvls[k][2]);
					e[0] = src_val(5'(c), 0, lvls[k][3]) ^ invs[k][3];
					check({5'h0, general_pin_out}, {5'h0, e});
					check({5'h0, pin_level}, {5'h0, e & pats[p][2:0]});
				end
			end
		end
		$display("pin sweep done");
		pulse(5'h15);
		rdr(OFF_OVF_STATUS, 8'h15);
		rdr(OFF_OVF_STATUS, 8'h00);
		pulse(5'h0a);
		rdr(OFF_OVF_STATUS, 8'h0a);
		rdr(OFF_OVF_STATUS, 8'h00);
		@(posedge ref_clk);
		ovf <= 5'h02;
		rdr(OFF_OVF_STATUS, 8'h02);
		@(posedge ref_clk);
		ovf <= 5'h00;
		rdr(OFF_OVF_STATUS, 8'h02);
		rdr(OFF_OVF_STATUS, 8'h00);
		$display("overflow flags done");
		finish_test();
	end
endmodule
`default_nettype wire
